// >>> logic/ccr_pkg.sv
package ccr_pkg;
	////////////////////////////////////////////////////////////////
	// Register addresses and field layouts
	localparam logic [7:0] ADDR_TIMERS     = 8'h05;
	localparam logic [7:0] ADDR_THRESHOLDS = 8'h06;
	localparam logic [7:0] ADDR_PULSE      = 8'h07;
	localparam logic [7:0] ADDR_TEMP       = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0B;
	localparam int         STATUS_FLAG_BIT = 3;
	// Arbitrary target address, not tied to any part
	localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h42;

	typedef struct packed {
		logic       termination_enable;
		logic       indicator_pin_disable;
		logic [1:0] host_timeout_select;
		logic       safety_timer_enable;
		logic [1:0] fast_charge_time_limit;
		logic       half_rate_timer_enable;
	} ccr_timers_type;

	typedef struct packed {
		logic       reserved;
		logic       plugin_source_detect_enable;
		logic [1:0] thermal_regulation_point;
		logic       charge_enable;
		logic       precharge_exit_threshold;
		logic [1:0] recharge_offset;
	} ccr_thresholds_type;

	typedef struct packed {
		logic       pulse_mode_disable;
		logic       host_timeout_kick;
		logic [1:0] top_off_duration;
		logic [3:0] reserved;
	} ccr_pulse_type;

	typedef struct packed {
		logic [2:0] reserved;
		logic [1:0] warm_voltage_setting;
		logic       warm_current_setting;
		logic [1:0] cool_current_setting;
	} ccr_temp_type;

	localparam logic [7:0] TIMERS_RST     = 8'h9D;
	localparam logic [7:0] THRESHOLDS_RST = 8'h7D;
	localparam logic [7:0] PULSE_RST      = 8'h00;
	localparam logic [7:0] TEMP_RST       = 8'h0D;
	localparam logic [7:0] WMASK_THRESH   = 8'h7F;
	localparam logic [7:0] WMASK_PULSE    = 8'hF0;
	localparam logic [7:0] WMASK_TEMP     = 8'h1F;
	localparam logic [7:0] PULSE_ONES     = 8'h02;
	localparam logic [7:0] KEEP_THRESH    = 8'h03;
	localparam logic [7:0] KEEP_PULSE     = 8'h80;

	////////////////////////////////////////////////////////////////
	// Timing: a 1 ms tick drives every long timer
	localparam int CLOCK_MHZ   = 100;
	localparam int TICK_US     = 1000;
	localparam int TICK_CYCLES = CLOCK_MHZ * TICK_US;
	localparam int MS_PER_S    = 1000;
	localparam int MS_PER_MIN  = 60 * MS_PER_S;
	localparam int MS_PER_H    = 60 * MS_PER_MIN;
	localparam int WD_40_S     = 40;
	localparam int WD_80_S     = 80;
	localparam int WD_160_S    = 160;
	localparam int CHG_5_H     = 5;
	localparam int CHG_8_H     = 8;
	localparam int CHG_12_H    = 12;
	localparam int CHG_20_H    = 20;
	localparam int TOP_15_MIN  = 15;
	localparam int TOP_30_MIN  = 30;
	localparam int TOP_45_MIN  = 45;
	localparam int TIMER_W     = 27;

	// Analog set points reported to the regulation loops
	localparam int PRECHG_LOW_MV  = 2800;
	localparam int PRECHG_HIGH_MV = 3000;
	localparam int RECHG_BASE_MV  = 50;
	localparam int RECHG_STEP_MV  = 50;
	localparam int THERMAL_REGULATION_POINT_BASE_C    = 60;
	localparam int THERMAL_REGULATION_POINT_STEP_C    = 20;
	localparam int WARM_LOW_MV    = 8000;
	localparam int WARM_HIGH_MV   = 8300;
	localparam int PCT_FULL       = 100;
	localparam int PCT_40         = 40;
	localparam int PCT_20         = 20;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_AACK = 4'h2,
		ST_PTR  = 4'h3,
		ST_PACK = 4'h4,
		ST_WR   = 4'h5,
		ST_WACK = 4'h6,
		ST_RD   = 4'h7,
		ST_RACK = 4'h8
	} ccr_state_type;

	typedef struct packed {
		logic        terminate_charge;
		logic        charge_run;
		logic        charge_suspend;
		logic        reverse_output_active;
		logic        pulse_mode_allowed;
		logic        source_detect_start;
		logic        safety_expired;
		logic        top_off_done;
		logic [6:0]  current_percent;
		logic        warm_target_valid;
		logic [13:0] warm_target_mv;
		logic [11:0] precharge_exit_mv;
		logic [7:0]  recharge_offset_mv;
		logic [6:0]  thermal_limit_c;
	} ccr_ctl_type;

	// Code 00 gives zero, meaning the timer is off
	function automatic logic [TIMER_W-1:0] code_to_ms(input logic [1:0] code, input int t1, input int t2,
		input int t3, input int unit_ms);
		int t;
		t = (code == 2'b01) ? t1 : (code == 2'b10) ? t2 : (code == 2'b11) ? t3 : 0;
		return TIMER_W'(t * unit_ms);
	endfunction : code_to_ms
endpackage : ccr_pkg

// >>> logic/ccr_ms_timer.sv
`timescale 1ns/1ns
module ccr_ms_timer (
	input  wire logic                        clock,
	input  wire logic                        sys_rst,
	input  wire logic                        restart,
	input  wire logic                        advance,
	input  wire logic [ccr_pkg::TIMER_W-1:0] limit,
	output logic                             expired
);
	import ccr_pkg::*;

	logic [TIMER_W-1:0] count;

	// Limit of zero means disabled; expiry holds until restarted
	always_ff @(posedge clock) begin
		if (sys_rst || restart) begin
			count   <= '0;
			expired <= 1'b0;
		end else if (advance && limit != '0 && !expired) begin
			if (count + 1'b1 >= limit)
				expired <= 1'b1;
			count <= count + 1'b1;
		end
	end
endmodule : ccr_ms_timer

// >>> logic/ccr_charger_control.sv
`timescale 1ns/1ns
// Summary of operation
// - Termination stops charging only while the termination enable bit is 1.
// - Indicator pin is driven while its disable bit is 0 and charging is 1, released otherwise.
// - Host timeout select: 00 off, 01 40 s, 10 80 s, 11 160 s.
// - Host writes kick bit 1 to restart timeout; device clears it afterwards.
// - Safety timer runs only while its enable bit is 1.
// - Fast-charge limit: 5, 8, 12 or 20 hours by code.
// - Half-rate bit slows safety timer during input limiting or thermal regulation.
// - Plug-in starts source detection only while auto detect enable is 1.
// - Thermal regulation point: 60, 80, 100 or 120 degrees by code.
// - Charge enable allows charging and wins over reverse output enable.
// - Precharge exit threshold is 2.8 V at 0, 3.0 V at 1.
// - Recharge offset is 50 mV plus 50 mV per code step.
// - Pulse mode operation allowed while its disable bit is 0.
// - Top-off duration: off, 15, 30 or 45 minutes by code.
// - Warm band voltage: suspend, 8.0 V, 8.3 V or unchanged.
// - Warm band current is 40 percent at 0, 100 percent at 1.
// - Cool band current: suspend, 20, 40 or 100 percent.
// - Reserved bits read 0, except bit 1 at address 07h reads 1.
// - Top bit of address 06h always reads 0.
// - Timeout flag reads 1 from expiry until the next kick, 0 otherwise.
module ccr_charger_control #(
	parameter int         TICK_CYCLES = ccr_pkg::TICK_CYCLES,
	parameter logic [6:0] I2C_ADDR    = ccr_pkg::I2C_ADDR_DEFAULT
) (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          i2c_scl,
	input  wire logic          i2c_sda_in,
	output logic               i2c_sda_out,
	output logic               i2c_sda_oe_n,
	input  wire logic          input_supply_rail,
	input  wire logic          temp_warm,
	input  wire logic          temp_cool,
	input  wire logic          input_limit_regulation,
	input  wire logic          thermal_regulation,
	input  wire logic          term_current_reached,
	input  wire logic          charging,
	input  wire logic          charge_start,
	input  wire logic          top_off_start,
	input  wire logic          reverse_output_enable,
	input  wire logic          reg_defaults_rst,
	output logic               indicator_out,
	output logic               indicator_oe_n,
	output logic               host_timeout_flag,
	output ccr_pkg::ccr_ctl_type ctl
);
	import ccr_pkg::*;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers: stage a is read only by stage b
	logic [7:0] pin_raw;
	logic [7:0] sync_a;
	logic [7:0] sync_b;
	logic       scl_d;
	logic       sda_d;
	logic       supply_d;

	assign pin_raw = {i2c_scl, i2c_sda_in, input_supply_rail, temp_warm,
		temp_cool, input_limit_regulation, thermal_regulation, term_current_reached};

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync_a <= 8'hC0;
			sync_b <= 8'hC0;
		end else begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
		end
	end

	wire scl_s    = sync_b[7];
	wire sda_s    = sync_b[6];
	wire supply_s = sync_b[5];
	wire warm_s   = sync_b[4];
	wire cool_s   = sync_b[3];
	wire ilim_s   = sync_b[2];
	wire thermal_regulation_point_s   = sync_b[1];
	wire iterm_s  = sync_b[0];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
			supply_d <= 1'b0;
		end else begin
			scl_d    <= scl_s;
			sda_d    <= sda_s;
			supply_d <= supply_s;
		end
	end

	// Bus conditions seen on the synchronised lines
	wire scl_rise  = scl_s & ~scl_d;
	wire scl_fall  = ~scl_s & scl_d;
	wire i2c_start = scl_s & scl_d & sda_d & ~sda_s;
	wire i2c_stop  = scl_s & scl_d & ~sda_d & sda_s;

	////////////////////////////////////////////////////////////////
	// Register storage
	ccr_timers_type     timers;
	ccr_thresholds_type thresholds;
	ccr_pulse_type      pulse;
	ccr_temp_type       temp;
	logic               wr_en;
	logic [7:0]         wr_addr;
	logic [7:0]         wr_data;
	logic               host_expired;
	logic               host_expired_d;
	// Registers go in as arguments so read data follows every change
	wire  [31:0]        reg_image = {timers, thresholds, pulse, temp};

	// Stored reserved bits are always zero; fixed ones are ORed in
	function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [31:0] regs, input logic flag);
		case (a)
			ADDR_TIMERS:     return regs[31:24];
			ADDR_THRESHOLDS: return regs[23:16] & WMASK_THRESH;
			ADDR_PULSE:      return regs[15:8] | PULSE_ONES;
			ADDR_TEMP:       return regs[7:0] & WMASK_TEMP;
			ADDR_STATUS:     return 8'(flag) << STATUS_FLAG_BIT;
			default:         return 8'h00;
		endcase
	endfunction : read_byte

	////////////////////////////////////////////////////////////////
	// I2C target: address, register pointer, data with auto-increment
	ccr_state_type state;
	logic [3:0]    bit_cnt;
	logic [7:0]    shift;
	logic [7:0]    ptr;
	logic [7:0]    tx;
	wire  [7:0]    rd_now  = read_byte(ptr, reg_image, host_timeout_flag);
	wire  [7:0]    rd_next = read_byte(ptr + 8'h01, reg_image, host_timeout_flag);
	wire           byte_done = (bit_cnt == 4'h8);

	always_ff @(posedge clock) begin
		wr_en <= 1'b0;
		if (sys_rst) begin
			state        <= ST_IDLE;
			bit_cnt      <= 4'h0;
			shift        <= 8'h00;
			ptr          <= 8'h00;
			tx           <= 8'h00;
			wr_addr      <= 8'h00;
			wr_data      <= 8'h00;
			i2c_sda_oe_n <= 1'b1;
		end else if (i2c_start) begin
			state        <= ST_ADDR;
			bit_cnt      <= 4'h0;
			i2c_sda_oe_n <= 1'b1;
		end else if (i2c_stop) begin
			state        <= ST_IDLE;
			i2c_sda_oe_n <= 1'b1;
		end else if (scl_rise) begin
			// Controller acknowledge: a high level ends the read
			if (state == ST_RACK) begin
				if (sda_s)
					state <= ST_IDLE;
			end else if (!byte_done) begin
				shift   <= {shift[6:0], sda_s};
				bit_cnt <= bit_cnt + 4'h1;
			end
		end else if (scl_fall) begin
			case (state)
				ST_ADDR: begin
					if (byte_done) begin
						if (shift[7:1] == I2C_ADDR) begin
							state        <= ST_AACK;
							i2c_sda_oe_n <= 1'b0;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					bit_cnt <= 4'h0;
					if (shift[0]) begin
						state        <= ST_RD;
						tx           <= rd_now;
						i2c_sda_oe_n <= rd_now[7];
					end else begin
						state        <= ST_PTR;
						i2c_sda_oe_n <= 1'b1;
					end
				end
				ST_PTR: begin
					if (byte_done) begin
						ptr          <= shift;
						state        <= ST_PACK;
						i2c_sda_oe_n <= 1'b0;
					end
				end
				ST_PACK: begin
					bit_cnt      <= 4'h0;
					state        <= ST_WR;
					i2c_sda_oe_n <= 1'b1;
				end
				ST_WR: begin
					if (byte_done) begin
						wr_en        <= 1'b1;
						wr_addr      <= ptr;
						wr_data      <= shift;
						state        <= ST_WACK;
						i2c_sda_oe_n <= 1'b0;
					end
				end
				ST_WACK: begin
					bit_cnt      <= 4'h0;
					ptr          <= ptr + 8'h01;
					state        <= ST_WR;
					i2c_sda_oe_n <= 1'b1;
				end
				ST_RD: begin
					if (byte_done) begin
						state        <= ST_RACK;
						i2c_sda_oe_n <= 1'b1;
					end else begin
						i2c_sda_oe_n <= tx[3'd7 - bit_cnt[2:0]];
					end
				end
				ST_RACK: begin
					bit_cnt      <= 4'h0;
					ptr          <= ptr + 8'h01;
					tx           <= rd_next;
					i2c_sda_oe_n <= rd_next[7];
					state        <= ST_RD;
				end
				default: begin
					state        <= ST_IDLE;
					i2c_sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Register updates: reset, timeout restore, host write, kick clear
	wire hit_timers = wr_en && wr_addr == ADDR_TIMERS;
	wire hit_thresh = wr_en && wr_addr == ADDR_THRESHOLDS;
	wire hit_pulse  = wr_en && wr_addr == ADDR_PULSE;
	wire hit_temp   = wr_en && wr_addr == ADDR_TEMP;
	wire reg_clear  = sys_rst | reg_defaults_rst;
	wire wd_event   = host_expired & ~host_expired_d;

	always_ff @(posedge clock) begin
		if (reg_clear || wd_event)
			timers <= ccr_timers_type'(TIMERS_RST);
		else if (hit_timers)
			timers <= ccr_timers_type'(wr_data);
	end

	always_ff @(posedge clock) begin
		if (reg_clear)
			thresholds <= ccr_thresholds_type'(THRESHOLDS_RST);
		else if (wd_event) // Recharge offset survives
			thresholds <= ccr_thresholds_type'((THRESHOLDS_RST & ~KEEP_THRESH) | (thresholds & KEEP_THRESH));
		else if (hit_thresh)
			thresholds <= ccr_thresholds_type'(wr_data & WMASK_THRESH);
	end

	// A new kick written in the clearing cycle wins
	always_ff @(posedge clock) begin
		if (reg_clear)
			pulse <= ccr_pulse_type'(PULSE_RST);
		else if (wd_event) // Pulse mode disable survives
			pulse <= ccr_pulse_type'((PULSE_RST & ~KEEP_PULSE) | (pulse & KEEP_PULSE));
		else if (hit_pulse)
			pulse <= ccr_pulse_type'(wr_data & WMASK_PULSE);
		else if (pulse.host_timeout_kick)
			pulse.host_timeout_kick <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (reg_clear || wd_event)
			temp <= ccr_temp_type'(TEMP_RST);
		else if (hit_temp)
			temp <= ccr_temp_type'(wr_data & WMASK_TEMP);
	end

	////////////////////////////////////////////////////////////////
	// Millisecond tick and the three timers
	// A one-cycle tick still needs a one-bit counter
	localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	logic [TICK_W-1:0]              tick_cnt;
	logic                           half_phase;
	logic                           safety_expired;
	logic                           top_off_done;
	wire                            tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

	always_ff @(posedge clock) begin
		if (sys_rst || tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
		half_phase <= sys_rst ? 1'b0 : half_phase ^ tick;
	end

	wire [TIMER_W-1:0] host_limit = code_to_ms(timers.host_timeout_select, WD_40_S, WD_80_S,
		WD_160_S, MS_PER_S);
	wire [TIMER_W-1:0] safety_limit = code_to_ms(timers.fast_charge_time_limit, CHG_8_H, CHG_12_H,
		CHG_20_H, MS_PER_H) | ((timers.fast_charge_time_limit == 2'b00) ? TIMER_W'(CHG_5_H * MS_PER_H)
		: '0);
	wire [TIMER_W-1:0] top_limit = code_to_ms(pulse.top_off_duration, TOP_15_MIN, TOP_30_MIN,
		TOP_45_MIN, MS_PER_MIN);
	// Half speed only while limiting or in thermal regulation
	wire slow_rate = timers.half_rate_timer_enable & (ilim_s | thermal_regulation_point_s);
	wire safety_adv = tick & charging & (~slow_rate | half_phase);

	// Kick restarts the count in the same edge that clears the bit
	ccr_ms_timer u_host_timer (
		.clock   (clock),
		.sys_rst (sys_rst),
		.restart (pulse.host_timeout_kick | (timers.host_timeout_select == 2'b00)),
		.advance (tick),
		.limit   (host_limit),
		.expired (host_expired)
	);

	ccr_ms_timer u_safety_timer (
		.clock   (clock),
		.sys_rst (sys_rst),
		.restart (charge_start | ~timers.safety_timer_enable),
		.advance (safety_adv),
		.limit   (safety_limit),
		.expired (safety_expired)
	);

	ccr_ms_timer u_top_timer (
		.clock   (clock),
		.sys_rst (sys_rst),
		.restart (top_off_start),
		.advance (tick),
		.limit   (top_limit),
		.expired (top_off_done)
	);

	// Flag set wins over a kick in the same cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			host_expired_d    <= 1'b0;
			host_timeout_flag <= 1'b0;
		end else begin
			host_expired_d <= host_expired;
			if (wd_event)
				host_timeout_flag <= 1'b1;
			else if (pulse.host_timeout_kick)
				host_timeout_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Charge control decode
	wire warm_susp = warm_s & (temp.warm_voltage_setting == 2'b00);
	wire cool_susp = cool_s & (temp.cool_current_setting == 2'b00);
	wire [6:0] warm_pct = temp.warm_current_setting ? 7'(PCT_FULL) : 7'(PCT_40);
	wire [6:0] cool_pct = (temp.cool_current_setting == 2'b11) ? 7'(PCT_FULL) :
		(temp.cool_current_setting == 2'b10) ? 7'(PCT_40) :
		(temp.cool_current_setting == 2'b01) ? 7'(PCT_20) : 7'h00;
	ccr_ctl_type next_ctl;

	always_comb begin
		next_ctl                       = '0;
		next_ctl.terminate_charge      = iterm_s & timers.termination_enable;
		next_ctl.charge_suspend        = warm_susp | cool_susp;
		next_ctl.charge_run            = thresholds.charge_enable & ~warm_susp & ~cool_susp
			& ~safety_expired;
		next_ctl.reverse_output_active = reverse_output_enable & ~thresholds.charge_enable;
		next_ctl.pulse_mode_allowed    = ~pulse.pulse_mode_disable;
		next_ctl.source_detect_start   = supply_s & ~supply_d
			& thresholds.plugin_source_detect_enable;
		next_ctl.safety_expired        = safety_expired;
		next_ctl.top_off_done          = top_off_done;
		next_ctl.current_percent       = warm_s ? warm_pct : cool_s ? cool_pct : 7'(PCT_FULL);
		next_ctl.warm_target_valid     = warm_s & (temp.warm_voltage_setting == 2'b01
			|| temp.warm_voltage_setting == 2'b10);
		next_ctl.warm_target_mv        = (temp.warm_voltage_setting == 2'b10) ? 14'(WARM_HIGH_MV)
			: 14'(WARM_LOW_MV);
		next_ctl.precharge_exit_mv     = thresholds.precharge_exit_threshold ? 12'(PRECHG_HIGH_MV)
			: 12'(PRECHG_LOW_MV);
		next_ctl.recharge_offset_mv    = 8'(RECHG_BASE_MV + RECHG_STEP_MV * int'(thresholds.recharge_offset));
		next_ctl.thermal_limit_c       = 7'(THERMAL_REGULATION_POINT_BASE_C + THERMAL_REGULATION_POINT_STEP_C
			* int'(thresholds.thermal_regulation_point));
	end

	// All outputs leave from flops
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctl            <= '0;
			indicator_out  <= 1'b0;
			indicator_oe_n <= 1'b1;
			i2c_sda_out    <= 1'b0;
		end else begin
			ctl            <= next_ctl;
			indicator_out  <= 1'b0;
			indicator_oe_n <= timers.indicator_pin_disable | ~charging;
			i2c_sda_out    <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_term;
		iterm_s && !timers.termination_enable |=> !ctl.terminate_charge;
	endproperty
	a_term: assert property (p_term) else $error("termination while disabled");

	property p_indicator;
		timers.indicator_pin_disable |=> indicator_oe_n;
	endproperty
	a_indicator: assert property (p_indicator) else $error("indicator driven while disabled");

	property p_kick;
		pulse.host_timeout_kick && !hit_pulse && !reg_clear |=> !pulse.host_timeout_kick;
	endproperty
	a_kick: assert property (p_kick) else $error("kick bit not cleared");

	property p_priority;
		!(ctl.reverse_output_active && $past(thresholds.charge_enable));
	endproperty
	a_priority: assert property (p_priority) else $error("reverse output beat charge enable");

	property p_restore;
		wd_event && !reg_clear |=> timers == ccr_timers_type'(TIMERS_RST)
			&& pulse.pulse_mode_disable == $past(pulse.pulse_mode_disable)
			&& thresholds.recharge_offset == $past(thresholds.recharge_offset);
	endproperty
	a_restore: assert property (p_restore) else $error("timeout restore wrong");

	property p_flag;
		wd_event |=> host_timeout_flag [*2];
	endproperty
	a_flag: assert property (p_flag) else $error("timeout flag not set");

	wire [7:0] rd_pulse_view  = read_byte(ADDR_PULSE, reg_image, host_timeout_flag);
	wire [7:0] rd_thresh_view = read_byte(ADDR_THRESHOLDS, reg_image, host_timeout_flag);
	wire [7:0] rd_temp_view   = read_byte(ADDR_TEMP, reg_image, host_timeout_flag);

	property p_rsvd;
		rd_pulse_view[3:0] == 4'h2 && !rd_thresh_view[7] && rd_temp_view[7:5] == 3'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");

	property p_detect;
		ctl.source_detect_start |-> $past(thresholds.plugin_source_detect_enable) ##1 !ctl.source_detect_start;
	endproperty
	a_detect: assert property (p_detect) else $error("detect start without enable");

	property p_safety_off;
		!timers.safety_timer_enable ##1 !timers.safety_timer_enable |-> !safety_expired;
	endproperty
	a_safety_off: assert property (p_safety_off) else $error("safety timer ran while off");

	c_write: cover property (hit_timers ##1 timers == ccr_timers_type'(wr_data));
	c_read: cover property (state == ST_RACK ##[1:200] state == ST_RD);
	c_expire: cover property (wd_event);
endmodule : ccr_charger_control

// >>> verif/ccr_i2c_host.sv
`timescale 1ns/1ns
// Bus controller model; SDA is only ever pulled low or released to the pull-up
module ccr_i2c_host (
	input  wire logic clock,
	output logic      scl,
	output logic      sda_o,
	input  wire logic sda_i
);
	import ccr_pkg::*;
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	task automatic hw(int n);
		repeat (n) @(posedge clock);
	endtask : hw
	// START is (1,0), STOP is (0,1); 8-clock phases clear the 5-clock minimum
	task automatic edge_seq(logic a, logic b);
		hw(1);
		scl <= 1'b0;
		hw(4);
		sda_o <= a;
		hw(4);
		scl <= 1'b1;
		hw(8);
		sda_o <= b;
		hw(8);
	endtask : edge_seq
	// Eight bits MSB first plus the acknowledge slot, sampled mid-high
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			hw(1);
			scl <= 1'b0;
			hw(4);
			sda_o <= d[i];
			hw(4);
			scl <= 1'b1;
			hw(4);
			r[i] = sda_i;
			hw(4);
		end
	endtask : xfer
	task automatic wr(logic [7:0] p, logic [7:0] v);
		logic [8:0] r;
		edge_seq(1'b1, 1'b0);
		xfer({I2C_ADDR_DEFAULT, 2'b01}, r);
		xfer({p, 1'b1}, r);
		xfer({v, 1'b1}, r);
		edge_seq(1'b0, 1'b1);
	endtask : wr
	// Pointer write, repeated START, one byte ended by NACK
	task automatic rd(logic [7:0] p, output logic [7:0] v);
		logic [8:0] r;
		edge_seq(1'b1, 1'b0);
		xfer({I2C_ADDR_DEFAULT, 2'b01}, r);
		xfer({p, 1'b1}, r);
		edge_seq(1'b1, 1'b0);
		xfer({I2C_ADDR_DEFAULT, 2'b11}, r);
		xfer(9'h1FF, r);
		v = r[8:1];
		edge_seq(1'b0, 1'b1);
	endtask : rd
endmodule : ccr_i2c_host

// >>> verif/charger_control_register_bank_tb_top.sv
`timescale 1ns/1ns
module charger_control_register_bank_tb_top;
	import ccr_pkg::*;
	logic        clock = 1'b0, sys_rst = 1'b1;
	logic        warm = 1'b0, cool = 1'b0, term = 1'b0, chg = 1'b0, rev = 1'b0, dflt = 1'b0, sup = 1'b0;
	logic        d_sda, oe_n, ind, ind_oe_n, flag;
	logic [7:0]  v;
	wire  logic  scl, hs, sda;
	ccr_ctl_type ctl;
	int          mismatches = 0, tests_run = 0;
	logic [15:0] rst_tab [5] = '{16'h059D, 16'h067D, 16'h0702, 16'h080D, 16'h0B00};
	logic [15:0] cool_tab [4] = '{16'h0000, 16'h0014, 16'h0028, 16'h0064};
	always #5 clock = ~clock;
	// Wired-AND of both parties on the pulled-up data line
	assign sda = hs & (oe_n | d_sda);
	// One-clock tick keeps the 40 s timeout inside the run
	ccr_charger_control #(.TICK_CYCLES(1)) dut (.clock(clock), .sys_rst(sys_rst), .i2c_scl(scl),
		.i2c_sda_in(sda), .i2c_sda_out(d_sda), .i2c_sda_oe_n(oe_n), .input_supply_rail(sup),
		.temp_warm(warm), .temp_cool(cool), .input_limit_regulation(1'b0), .thermal_regulation(1'b0),
		.term_current_reached(term), .charging(chg), .charge_start(1'b0), .top_off_start(1'b0),
		.reverse_output_enable(rev), .reg_defaults_rst(dflt), .indicator_out(ind),
		.indicator_oe_n(ind_oe_n), .host_timeout_flag(flag), .ctl(ctl));
	ccr_i2c_host host (.clock(clock), .scl(scl), .sda_o(hs), .sda_i(sda));
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	task automatic chk_out(logic [15:0] got, logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_out
	task automatic chk_reg(logic [7:0] p, logic [7:0] exp);
		host.rd(p, v);
		chk_out({8'h00, v}, {8'h00, exp});
	endtask : chk_reg
	// Hang guard, well beyond the expected run length
	initial begin
		repeat (95000) @(posedge clock);
		mismatches++;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		foreach (rst_tab[i]) chk_reg(rst_tab[i][15:8], rst_tab[i][7:0]);
		chk_out(16'(ind), 16'h0000);
		// Plug-in edge with detection enabled gives a single pulse
		sup <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk_out(16'(ctl.source_detect_start), 16'h0001);
		@(negedge clock);
		chk_out(16'(ctl.source_detect_start), 16'h0000);
		host.wr(8'h05, 8'h8D);
		chg <= 1'b1;
		term <= 1'b1;
		rev <= 1'b1;
		repeat (6) @(posedge clock);
		chk_out(16'({ctl.terminate_charge, ind_oe_n, ctl.charge_run, ctl.reverse_output_active}), 16'h000A);
		host.wr(8'h05, 8'h4C);
		repeat (6) @(posedge clock);
		chk_out(16'({ctl.terminate_charge, ind_oe_n, ctl.charge_run, ctl.reverse_output_active}), 16'h0006);
		host.wr(8'h06, 8'hFF);
		chk_reg(8'h06, 8'h7F);
		host.wr(8'h08, 8'hFF);
		chk_reg(8'h08, 8'h1F);
		// Every code of the thermal, precharge and recharge fields, charge enable toggled too
		for (int c = 0; c < 4; c++) begin
			host.wr(8'h06, {2'b01, c[1:0], c[1], c[0], c[1:0]});
			repeat (4) @(posedge clock);
			chk_out(16'(ctl.thermal_limit_c), 16'(60 + 20 * c));
			chk_out(16'(ctl.recharge_offset_mv), 16'(50 + 50 * c));
			chk_out(16'(ctl.precharge_exit_mv), c[0] ? 16'h0BB8 : 16'h0AF0);
			chk_out(16'(ctl.charge_run), 16'(c[1]));
			chk_out(16'(ctl.reverse_output_active), 16'(!c[1]));
		end
		warm <= 1'b1;
		host.wr(8'h08, 8'h11);
		repeat (6) @(posedge clock);
		chk_out(16'(ctl.current_percent), 16'h0028);
		chk_out(16'(ctl.warm_target_mv), 16'h206C);
		chk_out(16'(ctl.warm_target_valid), 16'h0001);
		warm <= 1'b0;
		cool <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			host.wr(8'h08, 8'(c));
			repeat (6) @(posedge clock);
			chk_out(16'(ctl.current_percent), cool_tab[c]);
			chk_out(16'(ctl.charge_suspend), 16'(c == 0));
		end
		cool <= 1'b0;
		// Timeout: kept fields survive expiry, the rest return home
		host.wr(8'h06, 8'h03);
		// Plug-in edge with detection disabled must stay quiet
		sup <= 1'b0;
		repeat (4) @(posedge clock);
		sup <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk_out(16'(ctl.source_detect_start), 16'h0000);
		host.wr(8'h05, 8'h9D);
		host.wr(8'h07, 8'hC0);
		chk_reg(8'h07, 8'h82);
		chk_out(16'(ctl.pulse_mode_allowed), 16'h0000);
		repeat (37000) @(posedge clock);
		chk_reg(8'h0B, 8'h00);
		repeat (2000) @(posedge clock);
		chk_reg(8'h0B, 8'h08);
		chk_out(16'(flag), 16'h0001);
		chk_reg(8'h06, 8'h7F);
		chk_reg(8'h07, 8'h82);
		host.wr(8'h07, 8'h40);
		chk_reg(8'h0B, 8'h00);
		chk_out(16'(flag), 16'h0000);
		chk_out(16'(ctl.pulse_mode_allowed), 16'h0001);
		dflt <= 1'b1;
		@(posedge clock);
		dflt <= 1'b0;
		chk_reg(8'h06, 8'h7D);
		test_done();
	end
endmodule : charger_control_register_bank_tb_top
